// ### sfq_pkg.sv
/*
  Shared constants for the serial flash command sequencer: opcodes,
  address and array widths, cycle timing and the host register map.
  Assumes a 20 MHz system clock on both ends.
*/
// Function
// R01 - Enter quad command mode only if quad-enable set
// R02 - Mode switches keep latch and suspend state
// R03 - Disable opcode returns device to single-line mode
// R04 - Erase and program need write-enable latch set
// R05 - Sector erase sets 4K sector to ones
// R06 - Erase: select rises right after last address byte
// R07 - Cycle starts at select rise, busy, latch cleared
// R08 - Protected regions are never erased or programmed
// R09 - Wide-address erase opcodes always take 32 bits
// R10 - Ordinary opcodes follow current address mode
// R11 - Half block erase sets 32K block to ones
// R12 - Full block erase sets 64K block to ones
// R13 - Two chip erase opcodes, no address, whole array
// R14 - Host unlocks globally before chip erase if needed
// R15 - Page write only turns ones into zeros
// R16 - Data past page end wraps within page
// R17 - Over 256 bytes: only last 256 kept
// R18 - Fewer bytes: written from start address only
// R19 - Page write: at least one whole data byte
// R20 - Host should write full aligned pages once
// R21 - Quad mode carries four bits per clock
package sfq_pkg;
  // Opcodes
  localparam logic [7:0] QUAD_COMMAND_MODE_ENTER        = 8'h38;
  localparam logic [7:0] QUAD_COMMAND_MODE_LEAVE        = 8'hFF;
  localparam logic [7:0] WRITE_ENABLE_COMMAND           = 8'h06;
  localparam logic [7:0] SECTOR_ERASE_CMD               = 8'h20;
  localparam logic [7:0] SECTOR_ERASE_WIDE_ADDR_CMD     = 8'h21;
  localparam logic [7:0] HALF_BLOCK_ERASE_CMD           = 8'h52;
  localparam logic [7:0] HALF_BLOCK_ERASE_WIDE_ADDR_CMD = 8'h5C;
  localparam logic [7:0] FULL_BLOCK_ERASE_CMD           = 8'hD8;
  localparam logic [7:0] FULL_BLOCK_ERASE_WIDE_ADDR_CMD = 8'hDC;
  localparam logic [7:0] CHIP_ERASE_CMD_A               = 8'h60;
  localparam logic [7:0] CHIP_ERASE_CMD_B               = 8'hC7;
  localparam logic [7:0] PAGE_WRITE_CMD                 = 8'h02;
  localparam logic [7:0] GLOBAL_UNLOCK_CMD              = 8'h98;
  localparam logic [7:0] ERASED_BYTE                    = 8'hFF;

  // Address lengths in bytes
  localparam logic [2:0] ADDR_BYTES_NARROW = 3'h3;
  localparam logic [2:0] ADDR_BYTES_WIDE   = 3'h4;

  // Array model: 4K bytes, one page is 256 bytes
  localparam int unsigned ARRAY_AW  = 12;
  localparam int unsigned PAGE_AW   = 8;
  localparam int unsigned DEVICE_AW = 25;
  localparam logic [11:0] ARRAY_LAST = 12'hFFF;
  localparam logic [7:0]  PAGE_LAST  = 8'hFF;
  localparam int unsigned PROT_MIN_AW = 16;
  localparam logic [4:0]  PROT_ALL_LEVEL = 5'h0A;

  // Timing
  localparam int unsigned CLOCK_HZ      = 20_000_000;
  localparam int unsigned CYCLES_PER_US = CLOCK_HZ / 1_000_000;
  localparam int unsigned SECTOR_ERASE_DURATION_US = 1000;
  localparam int unsigned BLOCK_ERASE_DURATION_US  = 2000;
  localparam int unsigned CHIP_ERASE_DURATION_US   = 4000;
  localparam int unsigned PAGE_WRITE_DURATION_US   = 100;
  localparam int unsigned SECTOR_ERASE_CYCLES =
    SECTOR_ERASE_DURATION_US * CYCLES_PER_US;
  localparam int unsigned BLOCK_ERASE_CYCLES =
    BLOCK_ERASE_DURATION_US * CYCLES_PER_US;
  localparam int unsigned CHIP_ERASE_CYCLES =
    CHIP_ERASE_DURATION_US * CYCLES_PER_US;
  localparam int unsigned PAGE_WRITE_CYCLES =
    PAGE_WRITE_DURATION_US * CYCLES_PER_US;
  localparam logic [2:0] SCLK_HALF_CYCLES = 3'h4;

  // Host register map and fields
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_LEN    = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;
  localparam logic [7:0] REG_FILL   = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int unsigned CTRL_ALEN_LSB = 8;
  localparam int unsigned CTRL_QUAD_BIT = 12;
endpackage

// ### sfq_link_if.sv
/*
  Link between the flash controller and the flash device.
  Assumes the host is the only driver of the IO lines; undriven
  lines read high as through pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
interface sfq_link_if;
  logic       cs_b;
  logic       sclk;
  logic [3:0] host_io_out;
  logic [3:0] host_io_oe_b;
  wire  [3:0] io;

  // Resolve each line from its enable
  assign io = (~host_io_oe_b & host_io_out) | host_io_oe_b;

  modport host (output cs_b, output sclk, output host_io_out,
                output host_io_oe_b);
  modport flash (input cs_b, input sclk, input io);
endinterface
`default_nettype wire

// ### sfq_flash.sv
/*
  Flash device end: command decoder, write-enable latch, quad mode,
  protection and self-timed erase and page write over a 4K model array.
  Assumes select, serial clock and IO arrive asynchronously and that
  the serial clock is much slower than the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sfq_flash #(
  parameter int unsigned SECTOR_CYCLES = sfq_pkg::SECTOR_ERASE_CYCLES,
  parameter int unsigned BLOCK_CYCLES  = sfq_pkg::BLOCK_ERASE_CYCLES,
  parameter int unsigned CHIP_CYCLES   = sfq_pkg::CHIP_ERASE_CYCLES,
  parameter int unsigned PAGE_CYCLES   = sfq_pkg::PAGE_WRITE_CYCLES
) (
  // Link
  sfq_link_if.flash  link,
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Configuration
  input  wire logic        quad_enable_bit,
  input  wire logic        addr4_mode,
  input  wire logic [4:0]  protect_bits,
  // Array inspection
  input  wire logic [11:0] peek_addr,
  output logic      [7:0]  peek_data,
  // Status
  output logic             busy_flag,
  output logic             write_enable_latch,
  output logic             qpi_mode
);
  // Address bytes for an opcode
  function automatic logic [2:0] addr_len(input logic [7:0] op,
                                          input logic a4);
    if (op == sfq_pkg::SECTOR_ERASE_WIDE_ADDR_CMD ||
        op == sfq_pkg::HALF_BLOCK_ERASE_WIDE_ADDR_CMD ||
        op == sfq_pkg::FULL_BLOCK_ERASE_WIDE_ADDR_CMD)
      addr_len = sfq_pkg::ADDR_BYTES_WIDE; // see R09
    else
      addr_len = a4 ? sfq_pkg::ADDR_BYTES_WIDE
                    : sfq_pkg::ADDR_BYTES_NARROW; // see R10
  endfunction

  // Top-of-array protection: level n guards the top 64K << (n-1)
  function automatic logic is_protected(input logic [4:0] bp,
                                        input logic [31:0] a);
    logic [25:0] span;
    span = 26'h0;
    if (bp == 5'h00)
      is_protected = 1'b0;
    else if (bp >= sfq_pkg::PROT_ALL_LEVEL)
      is_protected = 1'b1;
    else
    begin
      span = 26'(1) << (sfq_pkg::PROT_MIN_AW + 32'(bp) - 1);
      is_protected = {1'b0, a[24:0]} >= (26'(1) << sfq_pkg::DEVICE_AW)
                     - span;
    end
  endfunction

  logic [2:0]  cs_s;
  logic [2:0]  sck_s;
  logic [3:0]  io_s1;
  logic [3:0]  io_s2;
  logic [7:0]  shift;
  logic [3:0]  bit_cnt;
  logic [9:0]  byte_cnt;
  logic [7:0]  opcode;
  logic [31:0] addr;
  logic [255:0] pvalid;
  logic [7:0]  pbuf [0:255];
  logic [7:0]  mem  [0:4095];
  logic        walk_pp;
  logic        walk_done;
  logic [11:0] walk_ptr;
  logic [31:0] timer;

  // Two-flop synchronisers; third select and clock stage finds edges
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cs_s  <= 3'h7;
      sck_s <= 3'h0;
      io_s1 <= 4'hF;
      io_s2 <= 4'hF;
    end
    else
    begin
      cs_s  <= {cs_s[1:0], link.cs_b};
      sck_s <= {sck_s[1:0], link.sclk};
      io_s1 <= link.io;
      io_s2 <= io_s1;
    end
  end

  // Edge and byte framing
  wire        cs_fall   = ~cs_s[1] & cs_s[2];
  wire        cs_rise   = cs_s[1] & ~cs_s[2];
  wire        sck_rise  = ~cs_s[1] & sck_s[1] & ~sck_s[2];
  wire [3:0]  step      = qpi_mode ? 4'h4 : 4'h1; // see R21
  wire [7:0]  next_shift = qpi_mode ? {shift[3:0], io_s2}
                                    : {shift[6:0], io_s2[0]}; // see R21
  wire        byte_done = sck_rise && (bit_cnt + step == 4'h8);
  wire [2:0]  alen      = addr_len(opcode, addr4_mode);
  wire [9:0]  hdr       = 10'h1 + {7'h0, alen};
  wire [7:0]  data_idx  = 8'(byte_cnt - hdr);
  wire [7:0]  pb_slot   = addr[7:0] + data_idx; // see R16
  wire        is_pp     = opcode == sfq_pkg::PAGE_WRITE_CMD;
  wire        pb_write  = byte_done && !busy_flag && is_pp &&
                          byte_cnt >= hdr;

  // Command classification at select rise
  wire aligned  = bit_cnt == 4'h0;
  wire one_byte = aligned && byte_cnt == 10'h1;
  wire is_sect  = opcode == sfq_pkg::SECTOR_ERASE_CMD ||
                  opcode == sfq_pkg::SECTOR_ERASE_WIDE_ADDR_CMD;
  wire is_half  = opcode == sfq_pkg::HALF_BLOCK_ERASE_CMD ||
                  opcode == sfq_pkg::HALF_BLOCK_ERASE_WIDE_ADDR_CMD;
  wire is_full  = opcode == sfq_pkg::FULL_BLOCK_ERASE_CMD ||
                  opcode == sfq_pkg::FULL_BLOCK_ERASE_WIDE_ADDR_CMD;
  wire is_chip  = opcode == sfq_pkg::CHIP_ERASE_CMD_A ||
                  opcode == sfq_pkg::CHIP_ERASE_CMD_B; // see R13
  wire prot     = is_protected(protect_bits, addr); // see R08
  wire go_erase = (is_sect || is_half || is_full) && aligned &&
                  byte_cnt == hdr && !prot; // see R06
  wire go_chip  = is_chip && one_byte &&
                  protect_bits == 5'h00; // see R13 R08
  wire go_pp    = is_pp && aligned && byte_cnt > hdr && !prot; // see R19
  wire decide   = cs_rise && !busy_flag;
  wire start    = decide && write_enable_latch &&
                  (go_erase || go_chip || go_pp); // see R04 R07
  wire set_wel  = decide && one_byte &&
                  opcode == sfq_pkg::WRITE_ENABLE_COMMAND;
  wire enter_q  = decide && one_byte && quad_enable_bit && !qpi_mode &&
                  opcode == sfq_pkg::QUAD_COMMAND_MODE_ENTER; // see R01
  wire leave_q  = decide && one_byte && qpi_mode &&
                  opcode == sfq_pkg::QUAD_COMMAND_MODE_LEAVE; // see R03
  wire [31:0] dur = is_pp ? PAGE_CYCLES :
                    is_chip ? CHIP_CYCLES :
                    is_sect ? SECTOR_CYCLES : BLOCK_CYCLES;

  // Walk over the array while busy
  wire [11:0] walk_addr = walk_pp ? {addr[11:8], walk_ptr[7:0]}
                                  : walk_ptr;
  wire        walk_last = walk_pp ? walk_ptr[7:0] == sfq_pkg::PAGE_LAST
                                  : walk_ptr == sfq_pkg::ARRAY_LAST;
  wire        walk_wr   = busy_flag && !walk_done &&
                          (!walk_pp || pvalid[walk_ptr[7:0]]); // see R18
  wire [7:0]  walk_data = walk_pp ? mem[walk_addr] & pbuf[walk_ptr[7:0]]
                                  : sfq_pkg::ERASED_BYTE; // see R15 R05
  wire        finish    = busy_flag && walk_done && timer == 32'h0;

  // Frame decoder: opcode, address and byte counting
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift    <= 8'h00;
      bit_cnt  <= 4'h0;
      byte_cnt <= 10'h000;
      opcode   <= 8'h00;
      addr     <= 32'h0;
    end
    else if (cs_fall)
    begin
      bit_cnt  <= 4'h0;
      byte_cnt <= 10'h000;
      opcode   <= 8'h00;
      addr     <= busy_flag ? addr : 32'h0; // Running write keeps its page
    end
    else if (sck_rise && !busy_flag)
    begin
      shift   <= next_shift;
      bit_cnt <= byte_done ? 4'h0 : bit_cnt + step;
      if (byte_done)
      begin
        // Saturate so long data streams keep counting as data
        if (byte_cnt != 10'h3FF)
          byte_cnt <= byte_cnt + 10'h1;
        if (byte_cnt == 10'h000)
          opcode <= next_shift;
        else if (byte_cnt < hdr)
          addr <= {addr[23:0], next_shift}; // see R09 R10
      end
    end
  end

  // Page buffer valid map; later bytes overwrite earlier ones
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      pvalid <= 256'h0;
    else if (cs_fall && !busy_flag)
      pvalid <= 256'h0;
    else if (pb_write)
      pvalid[pb_slot] <= 1'b1; // see R17 R18
  end

  // Array storage has no reset
  always_ff @(posedge clock)
  begin
    if (pb_write)
      pbuf[pb_slot] <= next_shift; // see R16 R17
    if (walk_wr)
      mem[walk_addr] <= walk_data; // see R05 R11 R12 R13 R15
  end

  // Self-timed cycle; ends only when both timer and walk are done
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_flag <= 1'b0;
      walk_pp   <= 1'b0;
      walk_done <= 1'b0;
      walk_ptr  <= 12'h000;
      timer     <= 32'h0;
    end
    else if (start)
    begin
      busy_flag <= 1'b1; // see R07
      walk_pp   <= is_pp;
      walk_done <= 1'b0;
      walk_ptr  <= 12'h000;
      timer     <= dur;
    end
    else if (busy_flag)
    begin
      if (timer != 32'h0)
        timer <= timer - 32'h1;
      if (!walk_done)
      begin
        walk_ptr  <= walk_ptr + 12'h1;
        walk_done <= walk_last;
      end
      if (finish)
        busy_flag <= 1'b0; // see R07
    end
  end

  // Latch and mode; mode switches never touch the latch
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      write_enable_latch <= 1'b0;
      qpi_mode           <= 1'b0;
    end
    else
    begin
      if (finish)
        write_enable_latch <= 1'b0; // see R07
      else if (set_wel)
        write_enable_latch <= 1'b1; // see R04
      if (enter_q)
        qpi_mode <= 1'b1; // see R01 R02
      else if (leave_q)
        qpi_mode <= 1'b0; // see R03 R02
    end
  end

  // Registered view of the array
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      peek_data <= 8'h00;
    else
      peek_data <= mem[peek_addr];
  end
endmodule
`default_nettype wire

// ### sfq_host.sv
/*
  Flash controller end: Wishbone classic slave registers and a serial
  engine that sends opcode, address and fill-pattern data bytes.
  Assumes software orders commands correctly and polls the device.
*/
`timescale 1ns/1ps
`default_nettype none
module sfq_host (
  // Link
  sfq_link_if.host  link,
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Wishbone slave
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_cyc_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);
  typedef enum logic [1:0] {SFQ_IDLE, SFQ_SHIFT, SFQ_TAIL, SFQ_GAP}
    sfq_state_t;

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  sfq_state_t  state;
  logic [31:0] ctrl;
  logic [31:0] len;
  logic [31:0] addr;
  logic [31:0] fill;
  logic [2:0]  div;
  logic [2:0]  bit_pos;
  logic [10:0] byte_k;

  // Register decode
  wire        req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        wr     = req && wb_we_i;
  wire        idle   = state == SFQ_IDLE;
  wire        go     = wr && idle && wb_adr_i == sfq_pkg::REG_CTRL &&
                       wb_sel_i[0];
  wire [31:0] rd_mux = wb_adr_i == sfq_pkg::REG_CTRL ? ctrl :
                       wb_adr_i == sfq_pkg::REG_LEN  ? len :
                       wb_adr_i == sfq_pkg::REG_ADDR ? addr :
                       wb_adr_i == sfq_pkg::REG_FILL ? fill :
                       wb_adr_i == sfq_pkg::REG_STATUS ?
                         {31'h0, !idle} : 32'h0;

  // Frame layout
  wire [7:0]  op    = ctrl[7:0];
  wire [2:0]  alen  = ctrl[sfq_pkg::CTRL_ALEN_LSB +: 3];
  wire        quad  = ctrl[sfq_pkg::CTRL_QUAD_BIT]; // see R21
  wire [10:0] total = 11'h1 + {8'h0, alen} + {1'b0, len[9:0]};
  wire [10:0] didx  = byte_k - 11'h1 - {8'h0, alen};
  wire [1:0]  asel  = 2'(alen - 3'(byte_k));
  wire [7:0]  cur   = byte_k == 11'h0 ? op :
                      byte_k <= {8'h0, alen} ? addr[asel*8 +: 8] :
                      fill[7:0] + didx[7:0]; // see R09 R10
  wire [2:0]  step  = quad ? 3'h4 : 3'h1;
  wire        half  = div == sfq_pkg::SCLK_HALF_CYCLES - 3'h1;
  wire        lastb = bit_pos + step == 3'h0;
  wire [3:0]  bits  = quad ? (bit_pos[2] ? cur[3:0] : cur[7:4])
                           : {3'h7, cur[3'h7 - bit_pos]};

  // Wishbone answer one cycle after the request, dropped the next
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_mux : 32'h0;
    end
  end

  // Command registers; writes while a frame runs are ignored
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl <= 32'h0;
      len  <= 32'h0;
      addr <= 32'h0;
      fill <= 32'h0;
    end
    else if (wr && idle)
    begin
      if (wb_adr_i == sfq_pkg::REG_CTRL)
        ctrl <= merge(ctrl, wb_dat_i, wb_sel_i);
      if (wb_adr_i == sfq_pkg::REG_LEN)
        len <= merge(len, wb_dat_i, wb_sel_i);
      if (wb_adr_i == sfq_pkg::REG_ADDR)
        addr <= merge(addr, wb_dat_i, wb_sel_i);
      if (wb_adr_i == sfq_pkg::REG_FILL)
        fill <= merge(fill, wb_dat_i, wb_sel_i);
    end
  end

  // Serial engine: data changes after the falling edge, select rises
  // half a period after the last falling edge, on a byte boundary
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state   <= SFQ_IDLE;
      div     <= 3'h0;
      bit_pos <= 3'h0;
      byte_k  <= 11'h0;
      link.cs_b <= 1'b1;
      link.sclk <= 1'b0;
    end
    else
    begin
      div <= (idle || half) ? 3'h0 : div + 3'h1;
      unique case (state)
        SFQ_IDLE:
          if (go)
          begin
            state     <= SFQ_SHIFT;
            bit_pos   <= 3'h0;
            byte_k    <= 11'h0;
            link.cs_b <= 1'b0;
          end
        SFQ_SHIFT:
          if (half)
          begin
            link.sclk <= !link.sclk;
            if (link.sclk)
            begin
              bit_pos <= bit_pos + step;
              if (lastb)
              begin
                byte_k <= byte_k + 11'h1;
                if (byte_k + 11'h1 == total)
                  state <= SFQ_TAIL; // see R06 R19
              end
            end
          end
        SFQ_TAIL:
          if (half)
          begin
            link.cs_b <= 1'b1;
            state     <= SFQ_GAP;
          end
        SFQ_GAP:
          if (half)
            state <= SFQ_IDLE;
      endcase
    end
  end

  // IO drive, registered; single mode drives line 0 only
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link.host_io_out  <= 4'hF;
      link.host_io_oe_b <= 4'hF;
    end
    else
    begin
      link.host_io_out  <= state == SFQ_SHIFT ? bits : 4'hF;
      link.host_io_oe_b <= state != SFQ_SHIFT ? 4'hF :
                           quad ? 4'h0 : 4'hE; // see R21
    end
  end
endmodule
`default_nettype wire

// ### sfq_properties.sv
/*
  Checker for the flash link and the device status outputs.
  Assumes the bench places it beside the link that joins both ends.
*/
`timescale 1ns/1ps
`default_nettype none
module sfq_properties (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // Link
  input  wire logic       cs_b,
  input  wire logic       sclk,
  input  wire logic [3:0] io,
  // Device status
  input  wire logic       quad_enable_bit,
  input  wire logic       busy_flag,
  input  wire logic       write_enable_latch,
  input  wire logic       qpi_mode
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // Wire framing: clock idle, data steady while high, whole gaps
  property p_sclk_idle; cs_b |-> !sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("serial clock runs while deselected");
  property p_io_hold; sclk && $past(sclk) |-> $stable(io); endproperty
  a_io_hold: assert property (p_io_hold)
    else $error("data moved while serial clock high");
  property p_gap; $rose(cs_b) |-> cs_b [*4]; endproperty
  a_gap: assert property (p_gap)
    else $error("select gap shorter than four clocks");

  // Self-timed cycle starts after select rise and needs the latch
  property p_start_after_cs;
    $rose(busy_flag) |-> cs_b && $past(cs_b) && $past(cs_b, 2);
  endproperty
  a_start_after_cs: assert property (p_start_after_cs)
    else $error("busy rose while selected");
  property p_start_wel; $rose(busy_flag) |-> write_enable_latch; endproperty
  a_start_wel: assert property (p_start_wel)
    else $error("cycle started without write enable");
  property p_end_clear;
    $fell(busy_flag) |-> ##[0:2] !write_enable_latch;
  endproperty
  a_end_clear: assert property (p_end_clear)
    else $error("latch not cleared at cycle end");

  // Mode switching
  property p_qpi_qe; $rose(qpi_mode) |-> $past(quad_enable_bit); endproperty
  a_qpi_qe: assert property (p_qpi_qe)
    else $error("quad mode entered without enable");
  property p_mode_wel;
    $changed(qpi_mode) |-> $stable(write_enable_latch);
  endproperty
  a_mode_wel: assert property (p_mode_wel)
    else $error("mode switch changed the latch");
  property p_mode_idle; $changed(qpi_mode) |-> cs_b && !busy_flag; endproperty
  a_mode_idle: assert property (p_mode_idle)
    else $error("mode switched inside a frame");

  // Main scenarios
  c_busy: cover property ($rose(busy_flag));
  c_enter: cover property ($rose(qpi_mode));
  c_leave: cover property ($fell(qpi_mode));
  c_quad_busy: cover property (qpi_mode && $rose(busy_flag));
endmodule
`default_nettype wire

// ### serial_flash_erase_program_qpi_bench.sv
/*
  Bench: controller and device joined over the link, driven over Wishbone.
  Assumes the design files are compiled first; keeps its own array model.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_flash_erase_program_qpi_bench;
  // Clock, reset, configuration and status
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        quad_enable_bit = 1'b0;
  logic        addr4_mode = 1'b0;
  logic [4:0]  protect_bits = 5'h00;
  logic [11:0] peek_addr = 12'h000;
  logic [7:0]  peek_data;
  logic        busy_flag;
  logic        write_enable_latch;
  logic        qpi_mode;
  // Wishbone master, cyc and stb share one request
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [3:0]  wb_sel = 4'h0;
  logic        wb_we = 1'b0;
  logic        wb_req = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  // Expected state
  logic [7:0]  mem [4096];
  logic        ew = 1'b0;
  logic        eq = 1'b0;
  logic [15:0] sh = 16'h0;
  logic        sclk_d = 1'b0;
  int          seed = 64;
  int          n_fail = 0;
  int          check_count = 0;

  always #25 clock = ~clock;

  sfq_link_if link ();
  sfq_host sfq_host_i (.link(link), .clock(clock), .rst_b(rst_b),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
    .wb_we_i(wb_we), .wb_stb_i(wb_req), .wb_cyc_i(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  // Short durations: busy then lasts the internal walk
  sfq_flash #(.SECTOR_CYCLES(10), .BLOCK_CYCLES(10), .CHIP_CYCLES(10),
    .PAGE_CYCLES(10)) sfq_flash_i (.link(link), .clock(clock),
    .rst_b(rst_b), .quad_enable_bit(quad_enable_bit),
    .addr4_mode(addr4_mode), .protect_bits(protect_bits),
    .peek_addr(peek_addr), .peek_data(peek_data), .busy_flag(busy_flag),
    .write_enable_latch(write_enable_latch), .qpi_mode(qpi_mode));
  sfq_properties sfq_properties_i (.clock(clock), .rst_b(rst_b),
    .cs_b(link.cs_b), .sclk(link.sclk), .io(link.io),
    .quad_enable_bit(quad_enable_bit), .busy_flag(busy_flag),
    .write_enable_latch(write_enable_latch), .qpi_mode(qpi_mode));

  // Shift in what the wire carries at each serial clock rise
  always @(posedge clock)
  begin
    sclk_d <= link.sclk;
    if (link.sclk && !sclk_d)
      sh <= eq ? {sh[11:0], link.io} : {sh[14:0], link.io[0]};
  end

  task results;
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task check(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task hang;
    n_fail++;
    results;
  endtask

  // One classic cycle; the answer is awaited, never assumed
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
          output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    wb_req <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= 4'hF;
    do
    begin
      @(posedge clock);
      n++;
      if (n > 50) hang;
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_req <= 1'b0;
  endtask

  // Send one frame, wait out any cycle, update and compare the model
  task cmd(input logic [7:0] op, input logic [2:0] al, input int len,
           input logic [31:0] ad, input logic exp);
    logic [31:0] q;
    logic [7:0]  f;
    logic [7:0]  b;
    int          n;
    f = 8'($random(seed));
    wb(1'b1, sfq_pkg::REG_LEN, 32'(len), q);
    wb(1'b1, sfq_pkg::REG_ADDR, ad, q);
    wb(1'b1, sfq_pkg::REG_FILL, {24'h0, f}, q);
    wb(1'b1, sfq_pkg::REG_CTRL, {19'h0, eq, 1'b0, al, op}, q);
    n = 0;
    do
    begin
      wb(1'b0, sfq_pkg::REG_STATUS, 32'h0, q);
      n++;
      if (n > 4000) hang;
    end while (q[0] !== 1'b0);
    repeat (8) @(posedge clock);
    check("busy", busy_flag, exp);
    n = 0;
    while (busy_flag !== 1'b0)
    begin
      @(posedge clock);
      n++;
      if (n > 10000) hang;
    end
    if (op == 8'h06) ew = 1'b1;
    if (op == 8'h38 && quad_enable_bit) eq = 1'b1;
    if (op == 8'hFF) eq = 1'b0;
    if (exp)
    begin
      ew = 1'b0;
      if (op != 8'h02)
        foreach (mem[i]) mem[i] = 8'hFF;
      else
        for (int i = 0; i < len; i++)
          if (len - i <= 256)
          begin
            b = ad[7:0] + 8'(i);
            mem[{ad[11:8], b}] &= f + 8'(i);
          end
    end
    check("wel", write_enable_latch, ew);
    check("qpi", qpi_mode, eq);
    if (op == 8'h06) check("wire", sh[7:0], op);
  endtask

  // One page in full plus random bytes elsewhere
  task check_mem(input logic [3:0] pg);
    logic [11:0] a;
    for (int k = 0; k < 320; k++)
    begin
      a = (k < 256) ? {pg, 8'(k)} : 12'($random(seed));
      peek_addr <= a;
      repeat (2) @(posedge clock);
      check("array", peek_data, mem[a]);
    end
  endtask

  initial
  begin
    logic [31:0] q;
    logic [31:0] ad;
    logic [2:0]  al;
    logic [7:0]  ops [6];
    ops = '{8'h20, 8'h52, 8'hD8, 8'h21, 8'h5C, 8'hDC};
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    check("reset", {busy_flag, write_enable_latch, qpi_mode}, 3'h0);
    // Unmapped place is dropped and reads zero
    wb(1'b1, 8'h20, 32'h5A5A_5A5A, q);
    wb(1'b0, 8'h20, 32'h0, q);
    check("unmapped", q, 32'h0);
    // Chip erase refused without latch and under protection
    cmd(8'h60, 3'h0, 0, 32'h0, 1'b0);
    cmd(8'h06, 3'h0, 0, 32'h0, 1'b0);
    protect_bits <= 5'h01;
    cmd(8'h60, 3'h0, 0, 32'h0, 1'b0);
    protect_bits <= 5'h00;
    cmd(8'h60, 3'h0, 0, 32'h0, 1'b1);
    check_mem(4'h3);
    // Page write with no data, then one that wraps
    cmd(8'h06, 3'h0, 0, 32'h0, 1'b0);
    cmd(8'h02, 3'h3, 0, 32'h3FC, 1'b0);
    cmd(8'h02, 3'h3, 5, 32'h3FC, 1'b1);
    check_mem(4'h3);
    // Refusals that leave the latch set
    cmd(8'h06, 3'h0, 0, 32'h0, 1'b0);
    protect_bits <= 5'h0A;
    cmd(8'h02, 3'h3, 4, 32'h120, 1'b0);
    protect_bits <= 5'h00;
    cmd(8'h20, 3'h3, 1, 32'h0, 1'b0);
    cmd(8'h21, 3'h3, 0, 32'h0, 1'b0);
    // Quad mode: refused without enable, then over-long page write
    cmd(8'h38, 3'h0, 0, 32'h0, 1'b0);
    quad_enable_bit <= 1'b1;
    cmd(8'h38, 3'h0, 0, 32'h0, 1'b0);
    cmd(8'h02, 3'h3, 300, 32'h30A, 1'b1);
    check_mem(4'h3);
    cmd(8'h06, 3'h0, 0, 32'h0, 1'b0);
    cmd(8'hC7, 3'h0, 0, 32'h0, 1'b1);
    cmd(8'h06, 3'h0, 0, 32'h0, 1'b0);
    cmd(8'hFF, 3'h0, 0, 32'h0, 1'b0);
    // Every sector and block erase opcode, address mode toggling from one to the next
    for (int i = 0; i < 6; i++)
    begin
      addr4_mode <= i[0];
      al = (i > 2 || i[0]) ? 3'h4 : 3'h3;
      ad = $random(seed);
      cmd(8'h06, 3'h0, 0, 32'h0, 1'b0);
      cmd(8'h02, i[0] ? 3'h4 : 3'h3, 1 + ad[2:0], ad, 1'b1);
      check_mem(ad[11:8]);
      cmd(8'h06, 3'h0, 0, 32'h0, 1'b0);
      cmd(ops[i], al, 0, ad, 1'b1);
      check_mem(ad[11:8]);
    end
    results;
  end
endmodule
`default_nettype wire
